// ==== acr_pkg.sv ====
// Constants and types for the audio path configuration register bank
package acr_pkg;

  localparam logic [3:0]  AUDIO_PAGE     = 4'h2;
  localparam logic [5:0]  OFS_PATH_CTRL  = 6'h00;
  localparam logic [5:0]  OFS_REC_VOLUME = 6'h01;
  localparam logic [15:0] PATH_RESET     = 16'hc003;
  localparam logic [15:0] VOLUME_RESET   = 16'hd7d7;
  localparam logic [15:0] READ_UNMAPPED  = 16'h0000;

  localparam logic [6:0]  GAIN_MAX       = 7'h7f;
  localparam logic [6:0]  GAIN_UNITY     = 7'h57;
  localparam logic [6:0]  GAIN_MIN       = 7'h07;
  localparam logic [6:0]  GAIN_MUTED     = 7'h00;

  localparam logic [3:0]  RATE_LAST      = 4'h8;
  localparam logic [9:0]  RATIO_256      = 10'h100;
  localparam logic [9:0]  RATIO_384      = 10'h180;
  localparam logic [9:0]  RATIO_512      = 10'h200;
  localparam logic [3:0]  PREAMP_0DB     = 4'h0;
  localparam logic [3:0]  PREAMP_6DB     = 4'h6;
  localparam logic [3:0]  PREAMP_12DB    = 4'hc;

  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          STEP_TIME_NS   = 20000;
  localparam int          STEP_CYCLES    = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [11:0] STEP_LAST      = 12'(STEP_CYCLES - 1);

  typedef enum logic [1:0] {
    ACR_FILT_BYPASS = 2'h0,
    ACR_FILT_0P1    = 2'h1,
    ACR_FILT_78U    = 2'h2,
    ACR_FILT_19U    = 2'h3
  } acr_filter_t;

  typedef enum logic [1:0] {
    ACR_SRC_CAPSULE = 2'h0,
    ACR_SRC_LEFT    = 2'h1,
    ACR_SRC_RIGHT   = 2'h2,
    ACR_SRC_AVERAGE = 2'h3
  } acr_source_t;

  typedef enum logic [1:0] {
    ACR_FMT_16_RJ = 2'h0,
    ACR_FMT_20_RJ = 2'h1,
    ACR_FMT_20_LJ = 2'h2,
    ACR_FMT_20_IS = 2'h3
  } acr_format_t;

  typedef enum logic [1:0] {
    ACR_JUST_LEFT  = 2'h0,
    ACR_JUST_RIGHT = 2'h1,
    ACR_JUST_I2S   = 2'h2
  } acr_justify_t;

  typedef struct packed {
    acr_filter_t dc_block_filter_sel;
    acr_source_t left_record_source_sel;
    acr_source_t right_record_source_sel;
    logic [1:0]  preamp_gain_sel;
    logic [1:0]  clock_ratio_sel;
    logic [3:0]  sample_rate_code;
    acr_format_t audio_word_format;
  } acr_path_t;

  typedef struct packed {
    logic       left_record_mute;
    logic [6:0] left_record_gain;
    logic       right_record_mute;
    logic [6:0] right_record_gain;
  } acr_volume_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] page;
    logic [5:0] addr;
    logic [15:0] wdata;
  } acr_req_t;

  typedef struct packed {
    logic [6:0] gain_code;
    logic       common_mode_tie;
    logic       ramping;
  } acr_channel_t;

endpackage : acr_pkg

// ==== acr_config_regs.sv ====
// Path control and record volume registers with record gain soft-stepping
`timescale 1ns/1ps
module acr_config_regs (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire acr_pkg::acr_req_t req,
  output logic [15:0]        rdata,
  output logic               rvalid,
  output acr_pkg::acr_path_t path_cfg,
  output logic               filter_enable,
  output logic [9:0]         mclk_ratio,
  output logic [3:0]         preamp_gain_db,
  output logic [16:0]        sample_rate_hz,
  output logic               rate_code_valid,
  output logic               word_is_20bit,
  output acr_pkg::acr_justify_t playback_justify,
  output acr_pkg::acr_justify_t record_justify,
  output acr_pkg::acr_channel_t left_record_converter,
  output acr_pkg::acr_channel_t right_record_converter
);

  acr_pkg::acr_path_t   path_q;
  acr_pkg::acr_volume_t vol_q;
  logic [15:0]          rdata_q;
  logic                 rvalid_q;
  logic [11:0]          step_cnt_q;
  logic [6:0]           left_cur_q;
  logic [6:0]           right_cur_q;

  wire page_hit  = (req.page == acr_pkg::AUDIO_PAGE);
  wire hit_path  = page_hit && (req.addr == acr_pkg::OFS_PATH_CTRL);
  wire hit_vol   = page_hit && (req.addr == acr_pkg::OFS_REC_VOLUME);
  wire step_tick = (step_cnt_q == acr_pkg::STEP_LAST);

  // Target for the ramp: mute bit or an out-of-range code both end at mute
  function automatic logic [6:0] ramp_target(input logic mute, input logic [6:0] code);
    ramp_target = (mute || code < acr_pkg::GAIN_MIN) ? acr_pkg::GAIN_MUTED : code;
  endfunction : ramp_target

  // One half-decibel step; mute sits below the floor, so entry and exit jump
  function automatic logic [6:0] ramp_step(input logic [6:0] cur, input logic [6:0] tgt);
    if (cur > tgt) begin
      ramp_step = (cur <= acr_pkg::GAIN_MIN) ? acr_pkg::GAIN_MUTED : cur - 7'h01;
    end else if (cur < tgt) begin
      ramp_step = (cur < acr_pkg::GAIN_MIN) ? acr_pkg::GAIN_MIN : cur + 7'h01;
    end else begin
      ramp_step = cur;
    end
  endfunction : ramp_step

  function automatic acr_pkg::acr_justify_t justify_of(input acr_pkg::acr_format_t fmt, input logic playback);
    unique case (fmt)
      acr_pkg::ACR_FMT_16_RJ,
      acr_pkg::ACR_FMT_20_RJ: justify_of = playback ? acr_pkg::ACR_JUST_RIGHT : acr_pkg::ACR_JUST_LEFT;
      acr_pkg::ACR_FMT_20_LJ: justify_of = acr_pkg::ACR_JUST_LEFT;
      acr_pkg::ACR_FMT_20_IS: justify_of = acr_pkg::ACR_JUST_I2S;
    endcase
  endfunction : justify_of

  wire [6:0] left_tgt  = ramp_target(vol_q.left_record_mute, vol_q.left_record_gain);
  wire [6:0] right_tgt = ramp_target(vol_q.right_record_mute, vol_q.right_record_gain);

  wire [15:0] read_mux = hit_path ? 16'(path_q) :
                         hit_vol  ? 16'(vol_q)  : acr_pkg::READ_UNMAPPED;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      path_q <= acr_pkg::acr_path_t'(acr_pkg::PATH_RESET);
    end else if (req.wr && hit_path) begin
      path_q <= acr_pkg::acr_path_t'(req.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vol_q <= acr_pkg::acr_volume_t'(acr_pkg::VOLUME_RESET);
    end else if (req.wr && hit_vol) begin
      vol_q <= acr_pkg::acr_volume_t'(req.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= req.rd ? read_mux : rdata_q;
      rvalid_q <= req.rd;
    end
  end

  // Free-running step timer shared by both channels
  always_ff @(posedge clock) begin
    if (!reset_n || step_tick) begin
      step_cnt_q <= 12'h000;
    end else begin
      step_cnt_q <= step_cnt_q + 12'h001;
    end
  end

  // Gain starts muted, stays there while the reset mute bits are set, and walks up to the stored code once unmuted
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      left_cur_q  <= acr_pkg::GAIN_MUTED;
      right_cur_q <= acr_pkg::GAIN_MUTED;
    end else if (step_tick) begin
      left_cur_q  <= ramp_step(left_cur_q, left_tgt);
      right_cur_q <= ramp_step(right_cur_q, right_tgt);
    end
  end

  assign rdata    = rdata_q;
  assign rvalid   = rvalid_q;
  // Record source fields pass straight to the analog multiplexers
  assign path_cfg = path_q;

  assign filter_enable = (path_q.dc_block_filter_sel != acr_pkg::ACR_FILT_BYPASS);

  assign mclk_ratio = (path_q.clock_ratio_sel == 2'h1) ? acr_pkg::RATIO_384 :
                      (path_q.clock_ratio_sel == 2'h2) ? acr_pkg::RATIO_512 :
                                                         acr_pkg::RATIO_256;

  assign preamp_gain_db = (path_q.preamp_gain_sel == 2'h2) ? acr_pkg::PREAMP_6DB :
                          (path_q.preamp_gain_sel == 2'h3) ? acr_pkg::PREAMP_12DB :
                                                             acr_pkg::PREAMP_0DB;

  // Undefined rate codes are flagged and leave the rate output at zero
  assign rate_code_valid = (path_q.sample_rate_code <= acr_pkg::RATE_LAST);

  always_comb begin
    unique case (path_q.sample_rate_code)
      4'h0:    sample_rate_hz = 17'd48000;
      4'h1:    sample_rate_hz = 17'd44100;
      4'h2:    sample_rate_hz = 17'd32000;
      4'h3:    sample_rate_hz = 17'd24000;
      4'h4:    sample_rate_hz = 17'd22050;
      4'h5:    sample_rate_hz = 17'd16000;
      4'h6:    sample_rate_hz = 17'd12000;
      4'h7:    sample_rate_hz = 17'd11050;
      4'h8:    sample_rate_hz = 17'd8000;
      default: sample_rate_hz = 17'd0;
    endcase
  end

  assign word_is_20bit    = (path_q.audio_word_format != acr_pkg::ACR_FMT_16_RJ);
  assign playback_justify = justify_of(path_q.audio_word_format, 1'b1);
  assign record_justify   = justify_of(path_q.audio_word_format, 1'b0);

  assign left_record_converter.gain_code        = left_cur_q;
  assign left_record_converter.common_mode_tie  = (left_cur_q < acr_pkg::GAIN_MIN);
  assign left_record_converter.ramping          = (left_cur_q != left_tgt);
  assign right_record_converter.gain_code       = right_cur_q;
  assign right_record_converter.common_mode_tie = (right_cur_q < acr_pkg::GAIN_MIN);
  assign right_record_converter.ramping         = (right_cur_q != right_tgt);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Mute raised while the channel still sits above the floor
  sequence s_mute_request;
    $rose(vol_q.left_record_mute) && (left_cur_q > 7'h07);
  endsequence

  chk_reset_value_path: assert property ($rose(reset_n) |-> 16'(path_q) == 16'hc003)
    else $error("path register not at reset value");
  chk_path_write_store: assert property (req.wr && hit_path |=> 16'(path_q) == $past(req.wdata))
    else $error("path write not stored");
  chk_volume_readback: assert property (req.rd && hit_vol && !req.wr |=> rvalid && rdata == 16'(vol_q))
    else $error("volume readback wrong");
  chk_filter_bypass: assert property (filter_enable == (path_cfg.dc_block_filter_sel != 2'h0))
    else $error("filter enable decode wrong");
  chk_ratio_decode: assert property (path_cfg.clock_ratio_sel == 2'h3 |-> mclk_ratio == 10'd256)
    else $error("ratio code 3 not 256");
  chk_preamp_decode: assert property (path_cfg.preamp_gain_sel == 2'h1 |-> preamp_gain_db == 4'd0)
    else $error("preamp code 1 not 0 dB");
  chk_rate_decode: assert property (path_cfg.sample_rate_code == 4'h7 |-> sample_rate_hz == 17'd11050)
    else $error("rate code 7 decode wrong");
  chk_format_justify: assert property (path_cfg.audio_word_format == 2'h0 |->
                                       playback_justify == acr_pkg::ACR_JUST_RIGHT &&
                                       record_justify == acr_pkg::ACR_JUST_LEFT && !word_is_20bit)
    else $error("format 0 justification wrong");
  chk_i2s_framing: assert property (path_cfg.audio_word_format == 2'h3 |->
                                    playback_justify == acr_pkg::ACR_JUST_I2S && word_is_20bit)
    else $error("format 3 not I2S");
  chk_gain_single_step: assert property (left_cur_q >= 7'h07 && $past(left_cur_q) >= 7'h07 |->
                                         left_cur_q - $past(left_cur_q) <= 7'h01 ||
                                         $past(left_cur_q) - left_cur_q <= 7'h01)
    else $error("gain moved more than one step");
  chk_mute_ties_input: assert property (left_cur_q < 7'h07 |-> left_record_converter.common_mode_tie)
    else $error("muted channel not tied");
  chk_low_code_mutes: assert property (vol_q.right_record_gain < 7'h07 |-> right_tgt == 7'h00)
    else $error("low code does not mute");
  chk_left_source_field: assert property (req.wr && hit_path |=>
                                          path_cfg.left_record_source_sel == $past(req.wdata[13:12]))
    else $error("left source field misplaced");
  chk_right_source_field: assert property (req.wr && hit_path |=>
                                           path_cfg.right_record_source_sel == $past(req.wdata[11:10]))
    else $error("right source field misplaced");
  chk_mute_ramp_start: assert property (s_mute_request |->
                                        !left_record_converter.common_mode_tie [*2])
    else $error("mute skipped the ramp");

endmodule : acr_config_regs

// ==== acr_host_model.sv ====
// Host processor model driving the register port of the configuration bank
`timescale 1ns/1ps
module acr_host_model (
  input  wire logic        clock,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  output acr_pkg::acr_req_t req
);
  initial req = '0;

  // One strobe cycle from a falling edge; read data is taken one cycle later
  task automatic access(input logic w, input logic [3:0] pg, input logic [5:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic v);
    @(negedge clock);
    req <= '{wr: w, rd: !w, page: pg, addr: a, wdata: d};
    @(negedge clock);
    // Released fields carry inverted values so stale data cannot pass
    req <= '{wr: 1'b0, rd: 1'b0, page: ~pg, addr: ~a, wdata: ~d};
    q = rdata;
    v = rvalid;
  endtask : access
endmodule : acr_host_model

// ==== acr_config_regs_tb.sv ====
// Self-checking bench for the audio path configuration registers
`timescale 1ns/1ps
module acr_config_regs_tb;
  logic                  clock = 1'b0;
  logic                  reset_n = 1'b0;
  acr_pkg::acr_req_t     req;
  logic [15:0]           rdata;
  logic                  rvalid;
  acr_pkg::acr_path_t    path_cfg;
  logic                  filter_enable;
  logic [9:0]            mclk_ratio;
  logic [3:0]            preamp_gain_db;
  logic [16:0]           sample_rate_hz;
  logic                  rate_code_valid;
  logic                  word_is_20bit;
  acr_pkg::acr_justify_t pb_just;
  acr_pkg::acr_justify_t rec_just;
  acr_pkg::acr_channel_t left_ch;
  acr_pkg::acr_channel_t right_ch;
  logic [15:0]           q;
  logic                  v;
  logic [15:0]           d;
  int                    n_mismatch = 0;
  int                    tests_run = 0;
  int                    cycles = 0;
  int                    seed = 2;
  int                    model_gain = 0;
  int                    exp_q[$];

  acr_config_regs uut (.clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .path_cfg(path_cfg), .filter_enable(filter_enable),
    .mclk_ratio(mclk_ratio), .preamp_gain_db(preamp_gain_db), .sample_rate_hz(sample_rate_hz),
    .rate_code_valid(rate_code_valid), .word_is_20bit(word_is_20bit),
    .playback_justify(pb_just), .record_justify(rec_just),
    .left_record_converter(left_ch), .right_record_converter(right_ch));

  acr_host_model host (.clock(clock), .rdata(rdata), .rvalid(rvalid), .req(req));

  always #4 clock = ~clock;

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Ramp needs about nine steps of 2500 cycles; ceiling leaves wide margin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_decode(input logic [15:0] c);
    int hz[9] = '{48000, 44100, 32000, 24000, 22050, 16000, 12000, 11050, 8000};
    int ratio[4] = '{256, 384, 512, 256};
    int capsule_input[4] = '{0, 0, 6, 12};
    int pj[4] = '{1, 1, 0, 2};
    check(17'(path_cfg), 17'(c));
    check(17'(filter_enable), 17'(c[15:14] != 2'h0));
    check(17'(preamp_gain_db), 17'(capsule_input[c[9:8]]));
    check(17'(mclk_ratio), 17'(ratio[c[7:6]]));
    check(sample_rate_hz, 17'(hz[c[5:2]]));
    check(17'(rate_code_valid), 17'h1);
    check(17'(word_is_20bit), 17'(c[1:0] != 2'h0));
    check(17'(pb_just), 17'(pj[c[1:0]]));
    check(17'(rec_just), 17'((c[1:0] == 2'h3) ? 2 : 0));
  endtask : check_decode

  // Behavioural soft-step: one code per tick, 00 jumps to 07 and 07 drops to 00
  task automatic ramp(input int tgt);
    logic [6:0] prev;
    int n;
    int e;
    prev = 7'(model_gain);
    while (model_gain != tgt) begin
      if (tgt < 7) model_gain = (model_gain > 7) ? model_gain - 1 : 0;
      else if (model_gain == 0) model_gain = 7;
      else model_gain += (model_gain < tgt) ? 1 : -1;
      exp_q.push_back(model_gain);
    end
    while (exp_q.size() > 0) begin
      n = 0;
      while (left_ch.gain_code === prev && n < 2600) begin
        @(negedge clock);
        n++;
      end
      prev = left_ch.gain_code;
      e = exp_q.pop_front();
      check(17'(left_ch.gain_code), 17'(e));
      check(17'(left_ch.common_mode_tie), 17'(e < 7));
      check(17'(left_ch.ramping), 17'(e != tgt));
    end
  endtask : ramp

  initial begin
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    host.access(1'b0, 4'h2, 6'h00, 16'h0, q, v);
    check(17'(q), 17'hc003);
    check(17'(v), 17'h1);
    host.access(1'b0, 4'h2, 6'h01, 16'h0, q, v);
    check(17'(q), 17'hd7d7);
    check(17'(left_ch.common_mode_tie), 17'h1);
    check_decode(16'hc003);
    for (int i = 0; i < 18; i++) begin
      d = 16'($random(seed));
      d[15:14] = 2'(i);
      d[13:12] = 2'(i);
      d[9:6] = {2'(i), 2'(i >> 2)};
      d[5:2] = 4'(i % 9);
      d[1:0] = 2'(i);
      host.access(1'b1, 4'h2, 6'h00, d, q, v);
      check_decode(d);
      host.access(1'b0, 4'h2, 6'h00, 16'h0, q, v);
      check(17'(q), 17'(d));
    end
    host.access(1'b1, 4'h3, 6'h00, 16'hffff, q, v);
    host.access(1'b0, 4'h2, 6'h00, 16'h0, q, v);
    check(17'(q), 17'(d));
    host.access(1'b0, 4'h2, 6'h05, 16'h0, q, v);
    check(17'(q), 17'h0);
    host.access(1'b1, 4'h2, 6'h01, 16'h09d7, q, v);
    ramp(9);
    host.access(1'b1, 4'h2, 6'h01, 16'h89d7, q, v);
    ramp(0);
    host.access(1'b1, 4'h2, 6'h01, 16'h09d7, q, v);
    ramp(9);
    host.access(1'b0, 4'h2, 6'h01, 16'h0, q, v);
    check(17'(q), 17'h09d7);
    check(17'(right_ch), 17'h2);
    give_verdict();
  end
endmodule : acr_config_regs_tb
